//--- prt_consts.svh
// What this block does
// - Doubling repeats each raster address twice
// - Factor exact for heights multiple of four
// - Sync width and adjust never repeated
// - Raster repetition only expands, never shrinks
// - Signed five-bit cursor offset added to raster
// - Negative offset raster clamps to zero
// - Normal cursor uses software start and end
// - Fixed cursor shows on offset rasters two, three
// - Vertical MSB writes store zero unless extended
// - Stored vertical MSB survives enable clearing
// - Sync width programmable only when extended
// - Preset mode forces extended behaviour
// - Duty register holds lines per half minus one
// - Duty identical for dual and single drive
// - Dual drive width counts four-pixel units
// - Other panels count eight-pixel units
// - Vertical shift places first line marker
// - Reset clears fast access and slow blink
// - Repeat factor codes none, 1.5, 1.75, 2
`ifndef PRT_CONSTS_SVH
`define PRT_CONSTS_SVH
`define PRT_IDX_SYNC_W 8'h03
`define PRT_IDX_VTOTAL 8'h04
`define PRT_IDX_VADJ 8'h05
`define PRT_IDX_VDISP 8'h06
`define PRT_IDX_VSPOS 8'h07
`define PRT_IDX_MAXRA 8'h09
`define PRT_IDX_CSTART 8'h0A
`define PRT_IDX_CEND 8'h0B
`define PRT_IDX_DUTY 8'h20
`define PRT_IDX_LPEL 8'h21
`define PRT_IDX_VSHIFT 8'h22
`define PRT_IDX_HSHIFT 8'h23
`define PRT_IDX_PVSO 8'h32
`define PRT_IDX_PSYNC_W 8'h33
`define PRT_IDX_PVTOTAL 8'h34
`define PRT_IDX_PMAXRA 8'h36
`define PRT_IDX_REPEAT 8'h37
`define PRT_IDX_CURCTL 8'h40
`define PRT_IDX_MODE 8'h41
`define PRT_IDX_STATUS 8'h42
`define PRT_FAST_BIT 7
`define PRT_BLINK_BIT 6
`define PRT_FIXED_BIT 5
`define PRT_EXT_BIT 0
`define PRT_PRESET_BIT 1
`define PRT_DUAL_BIT 2
`define PRT_REG_RESET 8'h00
`define PRT_FIXED_VS_WIDTH 5'h10
`define PRT_FIXED_CUR_FIRST 5'h02
`define PRT_FIXED_CUR_LAST 5'h03
`endif

//--- prt_pkg.sv
package prt_pkg;
   typedef enum logic [0:0]
   {
      PRT_V_ROWS = 1'b0,
      PRT_V_ADJ = 1'b1
   } prt_vstate_t;
   typedef enum logic [1:0]
   {
      PRT_REP_NONE = 2'h0,
      PRT_REP_1P5 = 2'h1,
      PRT_REP_1P75 = 2'h2,
      PRT_REP_2X = 2'h3
   } prt_rep_t;
endpackage

//--- prt_cursor_match.sv
`timescale 1ns/10ps
`default_nettype none
`include "prt_consts.svh"
module prt_cursor_match
   import prt_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   // Raster and settings
   input wire logic [4:0] ra_in,
   input wire logic [4:0] offset_in,
   input wire logic fixed_in,
   input wire logic [4:0] start_in,
   input wire logic [4:0] end_in,
   // Result
   output logic hit_out
);
   logic signed [6:0] sum;
   logic [4:0] adj_ra;
   always_comb
   begin
      sum = $signed({2'h0, ra_in}) + $signed({{2{offset_in[4]}}, offset_in});
      adj_ra = sum[6] ? 5'h00 : sum[4:0];
   end
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         hit_out <= 1'b0;
      else if (ce_in)
      begin
         if (fixed_in)
            hit_out <= adj_ra == `PRT_FIXED_CUR_FIRST || adj_ra == `PRT_FIXED_CUR_LAST;
         else
            hit_out <= adj_ra >= start_in && adj_ra <= end_in;
      end
   end
   a_clamp_low: assert property (@(posedge clk_in) disable iff (!rstn_in)
      ce_in && offset_in == 5'h10 && ra_in == 5'h00 && !fixed_in
      && start_in == 5'h00 |=> hit_out)
      else $error("negative cursor raster not clamped to zero");
   a_fixed_ignores: assert property (@(posedge clk_in) disable iff (!rstn_in)
      ce_in && fixed_in && offset_in == 5'h00 && ra_in == 5'h05 |=> !hit_out)
      else $error("fixed cursor shown outside rasters two and three");
endmodule
`default_nettype wire

//--- prt_panel_timing.sv
`timescale 1ns/10ps
`default_nettype none
`include "prt_consts.svh"
module prt_panel_timing
   import prt_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   // Raster events
   input wire logic tick_in,
   input wire logic frame_in,
   // Settings from registers
   input wire logic [7:0] duty_in,
   input wire logic [7:0] lpel_in,
   input wire logic [7:0] vshift_in,
   input wire logic dual_in,
   // Panel timing
   output logic flm_out,
   output logic [7:0] line_out,
   output logic [11:0] pixels_out
);
   logic [7:0] duty_reg;
   logic [7:0] lpel_reg;
   logic [7:0] vshift_reg;
   logic dual_reg;
   logic active_reg;
   logic [8:0] cnt_reg;
   logic [8:0] cnt_next;
   logic [8:0] units;
   assign cnt_next = cnt_reg + 9'h001;
   assign units = {1'b0, lpel_reg} + 9'h001;
   // Shadows keep one frame's timing consistent
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         duty_reg <= `PRT_REG_RESET;
         lpel_reg <= `PRT_REG_RESET;
         vshift_reg <= `PRT_REG_RESET;
         dual_reg <= 1'b0;
      end
      else if (ce_in && frame_in)
      begin
         duty_reg <= duty_in;
         lpel_reg <= lpel_in;
         vshift_reg <= vshift_in;
         dual_reg <= dual_in;
      end
   end
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         cnt_reg <= 9'h000;
         active_reg <= 1'b0;
         flm_out <= 1'b0;
         line_out <= 8'h00;
      end
      else if (ce_in)
      begin
         flm_out <= 1'b0;
         if (frame_in)
         begin
            cnt_reg <= 9'h000;
            active_reg <= 1'b0;
         end
         else if (tick_in && !active_reg)
         begin
            cnt_reg <= cnt_next;
            if (cnt_next == {1'b0, vshift_reg} + 9'h001)
            begin
               flm_out <= 1'b1;
               active_reg <= 1'b1;
               line_out <= 8'h00;
            end
         end
         else if (tick_in)
            line_out <= line_out == duty_reg ? 8'h00 : line_out + 8'h01;
      end
   end
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         pixels_out <= 12'h000;
      else if (ce_in)
         pixels_out <= dual_reg ? {1'b0, units, 2'h0} : {units, 3'h0};
   end
   a_flm_after_shift: assert property (@(posedge clk_in) disable iff (!rstn_in)
      flm_out |-> cnt_reg == {1'b0, vshift_reg} + 9'h001)
      else $error("first line marker at wrong line");
endmodule
`default_nettype wire

//--- prt_top.sv
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "prt_consts.svh"
module prt_top
   import prt_pkg::*;
(
   // Clock, reset, enable
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   // Line rate from horizontal timing
   input wire logic line_tick_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [9:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Raster timing
   output logic [4:0] raster_addr_out,
   output logic vsync_n_out,
   output logic disp_en_out,
   output logic cursor_raster_out,
   // Panel timing
   output logic first_line_marker_out,
   output logic [7:0] panel_line_out,
   output logic [11:0] panel_pixels_out,
   // Host timing controls
   output logic fast_host_access_timing_out,
   output logic slow_blink_select_out
);
   logic [7:0] sync_w_reg;
   logic [7:0] vtotal_reg;
   logic [4:0] vadj_reg;
   logic [7:0] vdisp_reg;
   logic [7:0] vspos_reg;
   logic [4:0] maxra_reg;
   logic [4:0] cstart_reg;
   logic [4:0] cend_reg;
   logic [7:0] duty_reg;
   logic [7:0] lpel_reg;
   logic [7:0] vshift_reg;
   logic [7:0] hshift_reg;
   logic [7:0] pvso_reg;
   logic [7:0] psync_w_reg;
   logic [7:0] pvtotal_reg;
   logic [4:0] pmaxra_reg;
   prt_rep_t raster_repeat_factor_reg;
   logic [5:0] curctl_reg;
   logic [2:0] mode_reg;
   logic [7:0] idx;
   logic wr_take;
   logic rd_start;
   logic ext_eff;
   logic preset;
   logic [7:0] wr_vert;
   logic [31:0] rd_data;

   function automatic logic is_mapped(input logic [7:0] i);
      case (i)
         `PRT_IDX_SYNC_W, `PRT_IDX_VTOTAL, `PRT_IDX_VADJ, `PRT_IDX_VDISP,
         `PRT_IDX_VSPOS, `PRT_IDX_MAXRA, `PRT_IDX_CSTART, `PRT_IDX_CEND,
         `PRT_IDX_DUTY, `PRT_IDX_LPEL, `PRT_IDX_VSHIFT, `PRT_IDX_HSHIFT,
         `PRT_IDX_PVSO, `PRT_IDX_PSYNC_W, `PRT_IDX_PVTOTAL, `PRT_IDX_PMAXRA,
         `PRT_IDX_REPEAT, `PRT_IDX_CURCTL, `PRT_IDX_MODE, `PRT_IDX_STATUS:
            is_mapped = 1'b1;
         default:
            is_mapped = 1'b0;
      endcase
   endfunction

   // One wait state so that read data leaves a flip-flop
   assign idx = paddr_in[9:2];
   assign rd_start = psel_in && penable_in && !pready_out;
   assign wr_take = psel_in && penable_in && pready_out && pwrite_in;
   assign preset = mode_reg[`PRT_PRESET_BIT];
   assign ext_eff = mode_reg[`PRT_EXT_BIT] | preset;
   assign wr_vert = {ext_eff & pwdata_in[7], pwdata_in[6:0]};

   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
      end
      else if (ce_in)
      begin
         pready_out <= rd_start;
         if (rd_start)
         begin
            pslverr_out <= !is_mapped(idx);
            prdata_out <= pwrite_in ? 32'h0000_0000 : rd_data;
         end
         else
            pslverr_out <= 1'b0;
      end
   end

   // Vertical registers with a gated MSB keep it until rewritten
   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         vtotal_reg <= `PRT_REG_RESET;
         vdisp_reg <= `PRT_REG_RESET;
         vspos_reg <= `PRT_REG_RESET;
         pvtotal_reg <= `PRT_REG_RESET;
         pvso_reg <= `PRT_REG_RESET;
      end
      else if (ce_in && wr_take)
      begin
         case (idx)
            `PRT_IDX_VTOTAL: vtotal_reg <= wr_vert;
            `PRT_IDX_VDISP: vdisp_reg <= wr_vert;
            `PRT_IDX_VSPOS: vspos_reg <= wr_vert;
            `PRT_IDX_PVTOTAL: pvtotal_reg <= wr_vert;
            `PRT_IDX_PVSO: pvso_reg <= wr_vert;
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         sync_w_reg <= `PRT_REG_RESET;
         vadj_reg <= 5'h00;
         maxra_reg <= 5'h00;
         cstart_reg <= 5'h00;
         cend_reg <= 5'h00;
         duty_reg <= `PRT_REG_RESET;
         lpel_reg <= `PRT_REG_RESET;
         vshift_reg <= `PRT_REG_RESET;
         hshift_reg <= `PRT_REG_RESET;
         psync_w_reg <= `PRT_REG_RESET;
         pmaxra_reg <= 5'h00;
         raster_repeat_factor_reg <= PRT_REP_NONE;
         curctl_reg <= 6'h00;
         mode_reg <= 3'h0;
      end
      else if (ce_in && wr_take)
      begin
         case (idx)
            `PRT_IDX_SYNC_W: sync_w_reg <= pwdata_in[7:0];
            `PRT_IDX_VADJ: vadj_reg <= pwdata_in[4:0];
            `PRT_IDX_MAXRA: maxra_reg <= pwdata_in[4:0];
            `PRT_IDX_CSTART: cstart_reg <= pwdata_in[4:0];
            `PRT_IDX_CEND: cend_reg <= pwdata_in[4:0];
            `PRT_IDX_DUTY: duty_reg <= pwdata_in[7:0];
            `PRT_IDX_LPEL: lpel_reg <= pwdata_in[7:0];
            `PRT_IDX_VSHIFT: vshift_reg <= pwdata_in[7:0];
            `PRT_IDX_HSHIFT: hshift_reg <= pwdata_in[7:0];
            `PRT_IDX_PSYNC_W: psync_w_reg <= pwdata_in[7:0];
            `PRT_IDX_PMAXRA: pmaxra_reg <= pwdata_in[4:0];
            `PRT_IDX_REPEAT:
               raster_repeat_factor_reg <= prt_rep_t'(pwdata_in[1:0]);
            `PRT_IDX_CURCTL: curctl_reg <= pwdata_in[5:0];
            `PRT_IDX_MODE: mode_reg <= pwdata_in[2:0];
            default: ;
         endcase
      end
   end

   assign fast_host_access_timing_out = hshift_reg[`PRT_FAST_BIT];
   assign slow_blink_select_out = hshift_reg[`PRT_BLINK_BIT];

   // Vertical raster generator
   prt_vstate_t vstate_reg;
   logic [7:0] row_reg;
   logic [4:0] ra_reg;
   logic rep_reg;
   logic [4:0] adj_reg;
   logic [4:0] vs_cnt_reg;
   logic tick;
   logic [7:0] eff_vt;
   logic [4:0] eff_max;
   logic [7:0] eff_vsp;
   logic [4:0] vs_width;
   logic [3:0] sw_sel;
   logic [1:0] pos;
   logic signed [9:0] vsp_sum;
   logic vs_start;
   logic frame_start;

   function automatic logic rep_twice(input prt_rep_t f, input logic [1:0] p);
      case (f)
         PRT_REP_NONE: rep_twice = 1'b0;
         PRT_REP_1P5: rep_twice = !p[0];
         PRT_REP_1P75: rep_twice = p != 2'h3;
         PRT_REP_2X: rep_twice = 1'b1;
         default: rep_twice = 1'b0;
      endcase
   endfunction

   assign tick = ce_in && line_tick_in;
   always_comb
   begin
      eff_vt = preset ? pvtotal_reg : vtotal_reg;
      eff_max = preset ? pmaxra_reg : maxra_reg;
      vsp_sum = $signed({2'h0, vspos_reg}) + $signed({{2{pvso_reg[7]}}, pvso_reg});
      if (!preset)
         eff_vsp = vspos_reg;
      else if (vsp_sum < 0)
         eff_vsp = 8'h00;
      else
         eff_vsp = vsp_sum[7:0];
      sw_sel = preset ? psync_w_reg[7:4] : sync_w_reg[7:4];
      if (ext_eff && sw_sel != 4'h0)
         vs_width = {1'b0, sw_sel};
      else
         vs_width = `PRT_FIXED_VS_WIDTH;
      // Two-raster characters are sequenced as four via the row bit
      pos = eff_max == 5'h01 ? {row_reg[0], ra_reg[0]} : ra_reg[1:0];
   end
   assign vs_start = vstate_reg == PRT_V_ROWS && row_reg == eff_vsp
      && ra_reg == 5'h00 && !rep_reg && vs_cnt_reg == 5'h00;
   assign frame_start = tick && vs_cnt_reg == 5'h01;

   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         vstate_reg <= PRT_V_ROWS;
         row_reg <= 8'h00;
         ra_reg <= 5'h00;
         rep_reg <= 1'b0;
         adj_reg <= 5'h00;
      end
      else if (tick)
      begin
         case (vstate_reg)
            PRT_V_ROWS:
            begin
               if (!rep_reg && rep_twice(raster_repeat_factor_reg, pos))
                  rep_reg <= 1'b1;
               else
               begin
                  rep_reg <= 1'b0;
                  if (ra_reg != eff_max)
                     ra_reg <= ra_reg + 5'h01;
                  else
                  begin
                     ra_reg <= 5'h00;
                     if (row_reg != eff_vt)
                        row_reg <= row_reg + 8'h01;
                     else
                     begin
                        row_reg <= 8'h00;
                        adj_reg <= 5'h00;
                        if (vadj_reg != 5'h00)
                           vstate_reg <= PRT_V_ADJ;
                     end
                  end
               end
            end
            PRT_V_ADJ:
            begin
               // Adjust rasters count once each, never repeated
               if (adj_reg == vadj_reg - 5'h01)
                  vstate_reg <= PRT_V_ROWS;
               adj_reg <= adj_reg + 5'h01;
            end
            default:
               vstate_reg <= PRT_V_ROWS;
         endcase
      end
   end

   // Sync width counts physical lines, so repetition leaves it alone
   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         vs_cnt_reg <= 5'h00;
         vsync_n_out <= 1'b1;
      end
      else if (tick)
      begin
         if (vs_start)
         begin
            vs_cnt_reg <= vs_width;
            vsync_n_out <= 1'b0;
         end
         else if (vs_cnt_reg != 5'h00)
         begin
            vs_cnt_reg <= vs_cnt_reg - 5'h01;
            vsync_n_out <= vs_cnt_reg == 5'h01;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         raster_addr_out <= 5'h00;
         disp_en_out <= 1'b0;
      end
      else if (ce_in)
      begin
         raster_addr_out <= ra_reg;
         disp_en_out <= vstate_reg == PRT_V_ROWS && row_reg < vdisp_reg;
      end
   end

   prt_cursor_match u_cursor
   (
      .clk_in(mclk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .ra_in(ra_reg),
      .offset_in(curctl_reg[4:0]),
      .fixed_in(curctl_reg[`PRT_FIXED_BIT]),
      .start_in(cstart_reg),
      .end_in(cend_reg),
      .hit_out(cursor_raster_out)
   );

   prt_panel_timing u_panel
   (
      .clk_in(mclk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .tick_in(tick),
      .frame_in(frame_start),
      .duty_in(duty_reg),
      .lpel_in(lpel_reg),
      .vshift_in(vshift_reg),
      .dual_in(mode_reg[`PRT_DUAL_BIT]),
      .flm_out(first_line_marker_out),
      .line_out(panel_line_out),
      .pixels_out(panel_pixels_out)
   );

   always_comb
   begin
      rd_data = 32'h0000_0000;
      case (idx)
         `PRT_IDX_SYNC_W: rd_data[7:0] = sync_w_reg;
         `PRT_IDX_VTOTAL: rd_data[7:0] = vtotal_reg;
         `PRT_IDX_VADJ: rd_data[4:0] = vadj_reg;
         `PRT_IDX_VDISP: rd_data[7:0] = vdisp_reg;
         `PRT_IDX_VSPOS: rd_data[7:0] = vspos_reg;
         `PRT_IDX_MAXRA: rd_data[4:0] = maxra_reg;
         `PRT_IDX_CSTART: rd_data[4:0] = cstart_reg;
         `PRT_IDX_CEND: rd_data[4:0] = cend_reg;
         `PRT_IDX_DUTY: rd_data[7:0] = duty_reg;
         `PRT_IDX_LPEL: rd_data[7:0] = lpel_reg;
         `PRT_IDX_VSHIFT: rd_data[7:0] = vshift_reg;
         `PRT_IDX_HSHIFT: rd_data[7:0] = hshift_reg;
         `PRT_IDX_PVSO: rd_data[7:0] = pvso_reg;
         `PRT_IDX_PSYNC_W: rd_data[7:0] = psync_w_reg;
         `PRT_IDX_PVTOTAL: rd_data[7:0] = pvtotal_reg;
         `PRT_IDX_PMAXRA: rd_data[4:0] = pmaxra_reg;
         `PRT_IDX_REPEAT: rd_data[1:0] = raster_repeat_factor_reg;
         `PRT_IDX_CURCTL: rd_data[5:0] = curctl_reg;
         `PRT_IDX_MODE: rd_data[2:0] = mode_reg;
         `PRT_IDX_STATUS: rd_data[15:0] = {row_reg, 2'h0, vstate_reg, ra_reg};
         default: rd_data = 32'h0000_0000;
      endcase
   end

   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);

   sequence s_first_pass_2x;
      tick && vstate_reg == PRT_V_ROWS && !rep_reg
         && raster_repeat_factor_reg == PRT_REP_2X;
   endsequence
   a_double_hold: assert property (s_first_pass_2x |=> rep_reg
      && $stable(ra_reg))
      else $error("doubled raster advanced too early");
   a_onehalf_pattern: assert property (tick && vstate_reg == PRT_V_ROWS
      && !rep_reg && raster_repeat_factor_reg == PRT_REP_1P5 && pos[0]
      |=> !rep_reg)
      else $error("1.5x pattern repeated an odd raster");
   a_never_triple: assert property (tick && rep_reg |=> !rep_reg)
      else $error("raster repeated more than twice");
   a_adjust_single: assert property (vstate_reg == PRT_V_ADJ |-> !rep_reg)
      else $error("adjust raster repeated");
   a_msb_blocked: assert property (wr_take && ce_in && !ext_eff
      && idx == `PRT_IDX_VTOTAL |=> !vtotal_reg[7])
      else $error("vertical MSB written while blocked");
   a_msb_retained: assert property (!(wr_take && idx == `PRT_IDX_VTOTAL)
      |=> $stable(vtotal_reg))
      else $error("vertical total changed without a write");
   a_sync_fixed: assert property (tick && vs_start && !ext_eff
      |=> vs_cnt_reg == `PRT_FIXED_VS_WIDTH)
      else $error("sync width not sixteen when not extended");
   a_preset_ext: assert property (wr_take && ce_in && preset
      && idx == `PRT_IDX_PVTOTAL && pwdata_in[7] |=> pvtotal_reg[7])
      else $error("preset mode blocked MSB write");
   a_ready_pulse: assert property (ce_in && rd_start |=> pready_out ##1
      (!pready_out || !ce_in))
      else $error("APB ready not a single-cycle answer");
endmodule
`default_nettype wire

//--- prt_panel_model.sv
`timescale 1ns/10ps
`default_nettype none
module prt_panel_model
(
   // Timing seen by the panel
   input wire logic mclk_in,
   input wire logic vsync_n_in,
   input wire logic tick_in,
   input wire logic flm_in,
   // Lines counted from sync release to marker
   output logic [8:0] flm_lines_out
);
   logic [8:0] cnt_reg;
   logic vs_d_reg;
   // Panel only counts lines; it never drives the block
   always_ff @(posedge mclk_in)
   begin
      vs_d_reg <= vsync_n_in;
      if (vsync_n_in && !vs_d_reg)
         cnt_reg <= 9'h000;
      else if (tick_in)
         cnt_reg <= cnt_reg + 9'h001;
      if (flm_in)
         flm_lines_out <= cnt_reg;
   end
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "prt_consts.svh"
module tb;
   import prt_pkg::*;
   logic mclk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic line_tick_in = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, vsync_n, first_line_marker, fast, slow;
   logic [11:0] pix;
   logic [8:0] flm_lines;
   logic [4:0] ra_out;
   logic [7:0] pline;
   logic cur;
   logic cur_on = 1'b0;
   logic [1:0] cur_mask = 2'h0;
   logic [33:0] notes[$];
   logic [33:0] nt;
   logic [1:0] tcnt = 2'h0;
   logic [7:0] rv;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   int vs_run = 0;
   int vs_len = 0;
   always #20 mclk_in = ~mclk_in;
   prt_top prt_top_i (.mclk_in(mclk_in), .rstn_in(rstn_in), .ce_in(1'b1),
      .line_tick_in(line_tick_in), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .raster_addr_out(ra_out), .vsync_n_out(vsync_n), .disp_en_out(),
      .cursor_raster_out(cur), .first_line_marker_out(first_line_marker),
      .panel_line_out(pline), .panel_pixels_out(pix),
      .fast_host_access_timing_out(fast), .slow_blink_select_out(slow));
   prt_panel_model prt_panel_model_i (.mclk_in(mclk_in),
      .vsync_n_in(vsync_n), .tick_in(line_tick_in), .flm_in(first_line_marker),
      .flm_lines_out(flm_lines));
   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] idx,
      input logic [31:0] d, input logic [32:0] exp);
      notes.push_back({~w, exp});
      @(posedge mclk_in);
      psel <= 1'b1;
      pwr <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge mclk_in);
      pen <= 1'b1;
      // Only the bench timeout ends a stuck wait
      do @(posedge mclk_in); while (pready !== 1'b1);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      xfer(1'b1, idx, d, 33'h0);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 32'h0, {1'b0, exp});
   endtask
   task automatic cursor_case(input logic [7:0] ctl, input logic [7:0] last,
      input logic [1:0] mask);
      cur_on <= 1'b0;
      wr(`PRT_IDX_CEND, {24'h0, last});
      wr(`PRT_IDX_CURCTL, {24'h0, ctl});
      cur_mask <= mask;
      repeat (3) @(posedge mclk_in);
      cur_on <= 1'b1;
      repeat (40) @(posedge mclk_in);
   endtask
   // Oldest note pairs with each answer
   always @(posedge mclk_in)
      if (pready === 1'b1)
      begin
         nt = notes.pop_front();
         check({31'h0, pslverr}, {31'h0, nt[32]});
         if (nt[33])
            check(prdata, nt[31:0]);
      end
   always @(posedge mclk_in)
   begin
      tcnt <= tcnt + 2'h1;
      line_tick_in <= (tcnt == 2'h3);
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         conclude();
      end
   end
   // Sync length in lines, taken at its release
   always @(posedge mclk_in)
      if (vsync_n === 1'b1)
      begin
         if (vs_run != 0)
            vs_len = vs_run;
         vs_run = 0;
      end
      else if (line_tick_in)
         vs_run++;
   // Cursor and raster address leave the same edge, so they pair up
   always @(posedge mclk_in)
   begin
      if (cur_on && line_tick_in)
         check({31'h0, cur}, {31'h0, cur_mask[ra_out[0]]});
      if (first_line_marker === 1'b1)
         check({24'h0, pline}, 32'h0);
   end
   initial
   begin
      rv = $urandom(52310);
      repeat (6) @(posedge mclk_in);
      rstn_in <= 1'b1;
      check({30'h0, fast, slow}, 32'h0);
      rd(`PRT_IDX_HSHIFT, 32'h0);
      rd(`PRT_IDX_REPEAT, 32'h0);
      rd(`PRT_IDX_CURCTL, 32'h0);
      xfer(1'b1, 8'hFF, 32'h5A, {1'b1, 32'h0});
      xfer(1'b0, 8'hFF, 32'h0, {1'b1, 32'h0});
      for (int i = 0; i < 3; i++)
      begin
         rv = $urandom;
         wr(`PRT_IDX_DUTY + 8'(i), {24'h0, rv});
         rd(`PRT_IDX_DUTY + 8'(i), {24'h0, rv});
      end
      for (int k = 0; k < 4; k++)
      begin
         wr(`PRT_IDX_REPEAT, 32'(k));
         rd(`PRT_IDX_REPEAT, 32'(k));
      end
      wr(`PRT_IDX_HSHIFT, 32'hC0);
      @(posedge mclk_in);
      check({30'h0, fast, slow}, 32'h3);
      $display("test registers done");
      wr(`PRT_IDX_MODE, 32'h0);
      wr(`PRT_IDX_VTOTAL, 32'hFF);
      rd(`PRT_IDX_VTOTAL, 32'h7F);
      wr(`PRT_IDX_MODE, 32'h1);
      wr(`PRT_IDX_VTOTAL, 32'hFF);
      wr(`PRT_IDX_MODE, 32'h0);
      rd(`PRT_IDX_VTOTAL, 32'hFF);
      wr(`PRT_IDX_MODE, 32'h2);
      wr(`PRT_IDX_VSPOS, 32'h80);
      rd(`PRT_IDX_VSPOS, 32'h80);
      wr(`PRT_IDX_PVTOTAL, 32'h80);
      rd(`PRT_IDX_PVTOTAL, 32'h80);
      $display("test vertical msb done");
      wr(`PRT_IDX_MODE, 32'h1);
      wr(`PRT_IDX_SYNC_W, 32'h20);
      wr(`PRT_IDX_VTOTAL, 32'h3);
      wr(`PRT_IDX_VADJ, 32'h0);
      wr(`PRT_IDX_MAXRA, 32'h1);
      wr(`PRT_IDX_VDISP, 32'h2);
      wr(`PRT_IDX_VSPOS, 32'h2);
      wr(`PRT_IDX_DUTY, 32'h1);
      wr(`PRT_IDX_VSHIFT, 32'h3);
      wr(`PRT_IDX_LPEL, 32'h4F);
      wr(`PRT_IDX_REPEAT, 32'h0);
      // Row counter may be past the new total and must wrap first
      repeat (2600) @(posedge mclk_in);
      check(32'(vs_len), 32'h2);
      check({23'h0, flm_lines}, 32'h4);
      check({20'h0, pix}, 32'h280);
      cursor_case(8'h21, 8'h01, 2'h2);
      cursor_case(8'h1F, 8'h00, 2'h3);
      cursor_case(8'h01, 8'h01, 2'h1);
      cur_on <= 1'b0;
      $display("test cursor done");
      wr(`PRT_IDX_MODE, 32'h5);
      wr(`PRT_IDX_LPEL, 32'h9F);
      wr(`PRT_IDX_REPEAT, 32'h3);
      repeat (400) @(posedge mclk_in);
      check({20'h0, pix}, 32'h280);
      check(32'(vs_len), 32'h2);
      $display("test panel timing done");
      conclude();
   end
endmodule
`default_nettype wire
